// *** core/protection_fault_sequencer.sv ***
// Protection fault sequencer: pass switch control, hiccup timing,
// lockout counters, alarm pin and Wishbone status registers.
// Assumes comparator flags arrive asynchronously on pins.
// What this block does
// - Supply overvoltage opens switch, pulls alarm low.
// - Below release level, deglitch then reclose switch.
// - Overcurrent within 180us blanking is tolerated.
// - Overcurrent lasting 180us: off 64ms, alarm.
// - After 64ms, reclose and restart monitoring.
// - Fifteen overcurrent faults lock switch off.
// - Overcurrent count clears on power or enable.
// - Cell overvoltage opens switch, alarm low.
// - Cell below recovery level recloses switch.
// - Fifteen cell faults lock switch off.
// - Overheat opens switch; cooling below recloses.
// - Thermistor compared against two supply fractions.
// - Grounded thermistor disables window check.
// - Alarm open-drain, released when safe or disabled.
// - Enabled alarm pulls low on any fault.
`timescale 1ns/1ps
module protection_fault_sequencer (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rstn,
    // Comparator flags from the analog front end
    input  wire logic        supplyOverRise,
    input  wire logic        supplyOverFall,
    input  wire logic        cellOverRise,
    input  wire logic        cellOverFall,
    input  wire logic        overcurrentTrip,
    input  wire logic        heatOverRise,
    input  wire logic        heatOverFall,
    input  wire logic        thermAboveCold,
    input  wire logic        thermBelowHot,
    input  wire logic        thermGrounded,
    // Host enable, active low
    input  wire logic        enableN,
    // Pass switch and open-drain alarm
    output logic             switchOn,
    output logic             currentLimit,
    output logic             alarmOut,
    output logic             alarmOe,
    // Wishbone slave
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [3:0]  wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatI,
    output logic [31:0]      wbDatO,
    output logic             wbAck,
    // Interrupt
    output logic             irq
);
    localparam int NPIN = 11;

    logic            rstA_reg;
    logic            rstB_reg;
    logic            rstSyncN;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] s1_reg;
    logic [NPIN-1:0] s2_reg;
    logic [NPIN-1:0] s3_reg;
    logic [NPIN-1:0] pin_reg;
    logic [NPIN-1:0] pin_next;

    // Reset release passes two flops so that no register sees rstn rise
    // close to a clock edge.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rstA_reg <= 1'b0;
            rstB_reg <= 1'b0;
        end else begin
            rstA_reg <= 1'b1;
            rstB_reg <= rstA_reg;
        end
    end
    // Every register below resets on this copy. Assertion still acts at
    // once, and release lands on one edge for the whole block.
    assign rstSyncN = rstB_reg;

    // Pins pass three flops; a change counts once stages two and three agree.
    // Bit order: enable on top, supply flags at the bottom.
    assign pinRaw = {enableN, thermGrounded, thermBelowHot, thermAboveCold,
                     heatOverFall, heatOverRise, overcurrentTrip,
                     cellOverFall, cellOverRise, supplyOverFall,
                     supplyOverRise};
    wire [NPIN-1:0] pinAgree = ~(s2_reg ^ s3_reg);
    assign pin_next = pinAgree & s3_reg
                    | ~pinAgree & pin_reg;

    // The enable pin resets to its disabled level. Were it to reset low,
    // the switch would close for a few cycles while the chain fills, with
    // the host still holding the part off.
    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            s1_reg  <= prot_seq_pkg::PIN_RST;
            s2_reg  <= prot_seq_pkg::PIN_RST;
            s3_reg  <= prot_seq_pkg::PIN_RST;
            pin_reg <= prot_seq_pkg::PIN_RST;
        end else begin
            s1_reg  <= pinRaw;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            pin_reg <= pin_next;
        end
    end

    // Filtered comparator levels, one name per flag; disabled is high while
    // the host holds the enable pin at its off level.
    wire supOvr   = pin_reg[0];
    wire supFall  = pin_reg[1];
    wire cellOvr  = pin_reg[2];
    wire cellFall = pin_reg[3];
    wire ocTrip   = pin_reg[4];
    wire heatOvr  = pin_reg[5];
    wire heatFall = pin_reg[6];
    wire aboveCld = pin_reg[7];
    wire belowHot = pin_reg[8];
    wire thermGnd = pin_reg[9];
    wire disabled = pin_reg[10];

    // Power-on reset and this are the only ways out of a lockout.
    // Enable toggle: a disabled period clears counters and latches.
    wire clearAll = disabled;

    // Supply overvoltage with deglitched recovery.
    // The deglitch count restarts whenever the input climbs back above the
    // release level, so a ringing supply cannot close the switch early.
    logic        supFault_reg;
    logic [15:0] degCnt_reg;
    wire         degDone = degCnt_reg ==
                           16'(prot_seq_pkg::DEGLITCH_CYC - 1);
    wire         supSet = !clearAll && supOvr && !supFault_reg;

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            supFault_reg <= 1'b0;
            degCnt_reg   <= 16'h0000;
        end else if (clearAll) begin
            supFault_reg <= 1'b0;
            degCnt_reg   <= 16'h0000;
        end else if (supOvr) begin
            supFault_reg <= 1'b1;
            degCnt_reg   <= 16'h0000;
        end else if (supFault_reg && supFall) begin
            degCnt_reg   <= 16'h0000;
        end else if (supFault_reg) begin
            degCnt_reg   <= degCnt_reg + 16'h0001;
            if (degDone) begin
                supFault_reg <= 1'b0;
            end
        end
    end

    // Cell overvoltage hysteresis and lockout count.
    // The count saturates at the limit. Lockout keeps the switch open even
    // after the cell level itself has recovered.
    logic       cellFault_reg;
    logic [3:0] cellCnt_reg;
    wire        cellSet = !clearAll && cellOvr && !cellFault_reg;
    wire        cellLock = cellCnt_reg == prot_seq_pkg::FAULT_LIMIT;

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            cellFault_reg <= 1'b0;
            cellCnt_reg   <= 4'h0;
        end else if (clearAll) begin
            cellFault_reg <= 1'b0;
            cellCnt_reg   <= 4'h0;
        end else if (cellSet) begin
            cellFault_reg <= 1'b1;
            if (!cellLock) begin
                cellCnt_reg <= cellCnt_reg + 4'h1;
            end
        end else if (cellFault_reg && !cellFall && !cellOvr) begin
            cellFault_reg <= 1'b0;
        end
    end

    // Junction overheat hysteresis.
    // The rising flag sets the fault; the switch may close again only once
    // the falling flag has dropped as well.
    logic heatFault_reg;
    wire  heatSet = !clearAll && heatOvr && !heatFault_reg;

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            heatFault_reg <= 1'b0;
        end else if (clearAll) begin
            heatFault_reg <= 1'b0;
        end else if (heatOvr) begin
            heatFault_reg <= 1'b1;
        end else if (!heatFall) begin
            heatFault_reg <= 1'b0;
        end
    end

    // Thermistor window: fault outside band unless pin grounded.
    // The window is not latched: the switch follows it directly, and the
    // edge detector below only feeds the status register.
    wire thermFault = !thermGnd && (aboveCld || belowHot);
    logic thermPrev_reg;

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            thermPrev_reg <= 1'b0;
        end else begin
            thermPrev_reg <= thermFault;
        end
    end
    wire thermSet = !clearAll && thermFault && !thermPrev_reg;

    // Overcurrent blanking, hiccup and lockout.
    // One timer serves both the blanking window and the hiccup off time. It
    // restarts on every change of state, so each phase counts from zero.
    prot_seq_pkg::oc_state_t ocState_reg;
    prot_seq_pkg::oc_state_t ocState_next;
    logic [22:0] ocTimer_reg;
    logic [3:0]  ocCnt_reg;
    wire         blankDone = ocTimer_reg ==
                             23'(prot_seq_pkg::BLANK_CYC - 1);
    wire         hiccupDone = ocTimer_reg ==
                              23'(prot_seq_pkg::HICCUP_CYC - 1);
    wire         ocLockNow = ocCnt_reg ==
                             prot_seq_pkg::FAULT_LIMIT - 4'h1;
    wire         ocSet = ocState_reg == prot_seq_pkg::OC_BLANK
                         && ocTrip && blankDone;
    wire         timerClr = ocState_next != ocState_reg;

    // Leaving blanking early returns to normal running; a trip that lasts
    // the whole window either starts a hiccup or, at the limit, locks out.
    always_comb begin
        case (ocState_reg)
            prot_seq_pkg::OC_RUN: begin
                ocState_next = ocTrip ? prot_seq_pkg::OC_BLANK
                                      : prot_seq_pkg::OC_RUN;
            end
            prot_seq_pkg::OC_BLANK: begin
                if (!ocTrip) begin
                    ocState_next = prot_seq_pkg::OC_RUN;
                end else if (blankDone) begin
                    ocState_next = ocLockNow ? prot_seq_pkg::OC_LOCK
                                             : prot_seq_pkg::OC_OFF;
                end else begin
                    ocState_next = prot_seq_pkg::OC_BLANK;
                end
            end
            prot_seq_pkg::OC_OFF: begin
                ocState_next = hiccupDone ? prot_seq_pkg::OC_RUN
                                          : prot_seq_pkg::OC_OFF;
            end
            prot_seq_pkg::OC_LOCK: begin
                ocState_next = prot_seq_pkg::OC_LOCK;
            end
            default: begin
                ocState_next = prot_seq_pkg::OC_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            ocState_reg <= prot_seq_pkg::OC_RUN;
            ocTimer_reg <= 23'h000000;
            ocCnt_reg   <= 4'h0;
        end else if (clearAll) begin
            ocState_reg <= prot_seq_pkg::OC_RUN;
            ocTimer_reg <= 23'h000000;
            ocCnt_reg   <= 4'h0;
        end else begin
            ocState_reg <= ocState_next;
            ocTimer_reg <= timerClr ? 23'h000000 : ocTimer_reg + 23'h000001;
            if (ocSet && ocCnt_reg != prot_seq_pkg::FAULT_LIMIT) begin
                ocCnt_reg <= ocCnt_reg + 4'h1;
            end
        end
    end

    // The switch is open for the whole hiccup and for good after lockout.
    // Lockout is reported once, on the fault that reaches the limit.
    wire ocOff = ocState_reg == prot_seq_pkg::OC_OFF
              || ocState_reg == prot_seq_pkg::OC_LOCK;
    wire lockSet = !clearAll && ocSet && ocLockNow
                || cellSet && cellCnt_reg == prot_seq_pkg::FAULT_LIMIT - 4'h1;

    // Switch and alarm drive.
    // Both outputs are flops fed from the same terms, so the switch and the
    // alarm change on one edge and never disagree. The alarm pin only ever
    // pulls low; its data is fixed and the enable carries the level.
    wire anyFault = supFault_reg || cellFault_reg || cellLock || ocOff
                 || heatFault_reg || thermFault;
    wire switchNext = !disabled && !anyFault;
    wire alarmNext  = !disabled && anyFault;

    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            switchOn     <= 1'b0;
            currentLimit <= 1'b0;
            alarmOe      <= 1'b0;
        end else begin
            switchOn     <= switchNext;
            currentLimit <= ocState_reg == prot_seq_pkg::OC_BLANK;
            alarmOe      <= alarmNext;
        end
    end
    assign alarmOut = 1'b0;

    // Event status, enable and clear registers.
    // Each event is a one-cycle pulse, so a bit stays set after its cause
    // has gone until software writes a one to the same bit of clear.
    // The enable register only masks the interrupt, never the status.
    logic [prot_seq_pkg::EV_W-1:0] status_reg;
    logic [prot_seq_pkg::EV_W-1:0] irqEn_reg;
    logic [prot_seq_pkg::EV_W-1:0] evSet;
    logic [prot_seq_pkg::EV_W-1:0] evClr;
    assign evSet = {lockSet, thermSet, heatSet, ocSet, cellSet, supSet};

    // A request is taken while ack is low and answered one cycle later.
    // Writes land on the edge that sees ack high, the edge at which the
    // master completes, so a request held over ack cannot write twice.
    wire wbReq   = wbCyc && wbStb && !wbAck;
    wire wbWrite = wbCyc && wbStb && wbAck && wbWe && wbSel[0];
    wire selStat = wbAdr == prot_seq_pkg::OFF_STATUS;
    wire selClr  = wbAdr == prot_seq_pkg::OFF_CLEAR;
    wire selEn   = wbAdr == prot_seq_pkg::OFF_ENABLE;
    wire selSt   = wbAdr == prot_seq_pkg::OFF_STATE;
    assign evClr = (wbWrite && selClr) ? wbDatI[prot_seq_pkg::EV_W-1:0]
                                       : '0;

    // A set in the same cycle as its clear wins.
    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            status_reg <= '0;
            irqEn_reg  <= prot_seq_pkg::IRQ_EN_RST;
        end else begin
            status_reg <= (status_reg & ~evClr) | evSet;
            if (wbWrite && selEn) begin
                irqEn_reg <= wbDatI[prot_seq_pkg::EV_W-1:0];
            end
        end
    end
    // The interrupt is a level that follows the masked status directly.
    assign irq = |(status_reg & irqEn_reg);

    // The state word gathers the live outputs and both fault counters so
    // that software can poll the lockout progress.
    logic [31:0] stateWord;
    always_comb begin
        stateWord = 32'h00000000;
        stateWord[prot_seq_pkg::ST_SWITCH] = switchOn;
        stateWord[prot_seq_pkg::ST_ALARM] = alarmOe;
        stateWord[prot_seq_pkg::ST_OCP_CNT +: 4] = ocCnt_reg;
        stateWord[prot_seq_pkg::ST_CELL_CNT +: 4] = cellCnt_reg;
    end

    // Unmapped offsets and the write-only clear register read as zero.
    wire [31:0] rdMux = selStat ? {26'h0, status_reg}
                      : selEn   ? {26'h0, irqEn_reg}
                      : selSt   ? stateWord
                      : 32'h00000000;

    // Read data is registered with the acknowledge and is zero outside a
    // read, so the bus never shows a stale word.
    always_ff @(posedge mclk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            wbAck  <= 1'b0;
            wbDatO <= 32'h00000000;
        end else begin
            wbAck  <= wbReq;
            wbDatO <= (wbReq && !wbWe) ? rdMux : 32'h00000000;
        end
    end
endmodule : protection_fault_sequencer

// *** shared/prot_seq_pkg.sv ***
// Constants for the protection fault sequencer.
// Assumes a 100 MHz system clock and a classic Wishbone register port.
package prot_seq_pkg;
    localparam int CLK_MHZ = 100;
    // Timing figures in their own units, then cycle counts.
    localparam int BLANK_US = 180;
    localparam int BLANK_CYC = BLANK_US * CLK_MHZ;
    localparam int HICCUP_MS = 64;
    localparam int HICCUP_CYC = HICCUP_MS * 1000 * CLK_MHZ;
    localparam int DEGLITCH_US = 10;
    localparam int DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
    localparam logic [3:0] FAULT_LIMIT = 4'hF;
    // Synchroniser reset: the enable pin (top bit) idles high.
    localparam logic [10:0] PIN_RST = 11'h400;
    // Register byte offsets.
    localparam logic [3:0] OFF_STATUS = 4'h0;
    localparam logic [3:0] OFF_CLEAR = 4'h4;
    localparam logic [3:0] OFF_ENABLE = 4'h8;
    localparam logic [3:0] OFF_STATE = 4'hC;
    // Event bit positions in status, clear and enable.
    localparam int EV_SUPPLY = 0;
    localparam int EV_CELL = 1;
    localparam int EV_OCP = 2;
    localparam int EV_HEAT = 3;
    localparam int EV_THERM = 4;
    localparam int EV_LOCK = 5;
    localparam int EV_W = 6;
    localparam logic [5:0] IRQ_EN_RST = 6'h00;
    // State register fields.
    localparam int ST_SWITCH = 0;
    localparam int ST_ALARM = 1;
    localparam int ST_OCP_CNT = 8;
    localparam int ST_CELL_CNT = 12;
    typedef enum logic [3:0] {
        OC_RUN   = 4'h1,
        OC_BLANK = 4'h2,
        OC_OFF   = 4'h4,
        OC_LOCK  = 4'h8
    } oc_state_t;
endpackage : prot_seq_pkg

// *** tb/prot_seq_checker.sv ***
// Port checker of the protection fault sequencer.
// Assumes one clock domain; the testbench top binds it to the design.
`timescale 1ns/1ps
module prot_seq_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Flags and enable
    input wire logic supplyOverRise,
    input wire logic cellOverRise,
    input wire logic heatOverRise,
    input wire logic thermAboveCold,
    input wire logic thermGrounded,
    input wire logic enableN,
    // Outputs and bus
    input wire logic switchOn,
    input wire logic currentLimit,
    input wire logic alarmOut,
    input wire logic alarmOe,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbAck
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence s_req; wbCyc && wbStb && !wbAck; endsequence
    sequence s_ack; wbAck ##1 !wbAck; endsequence
    sequence s_open; !switchOn && alarmOe; endsequence
    property p_ack; s_req |=> s_ack; endproperty
    property p_data; alarmOe |-> alarmOut == 1'b0; endproperty
    property p_off; enableN [*8] |-> !switchOn && !alarmOe; endproperty
    property p_supply; (supplyOverRise && !enableN) [*8] |-> s_open;
    endproperty
    property p_cell; (cellOverRise && !enableN) [*8] |-> s_open; endproperty
    property p_heat; (heatOverRise && !enableN) [*8] |-> s_open; endproperty
    property p_therm;
        (thermAboveCold && !thermGrounded && !enableN) [*8] |-> s_open;
    endproperty
    property p_alarm; (!enableN) [*8] |-> alarmOe != switchOn; endproperty
    property p_blank; currentLimit |-> switchOn && !alarmOe; endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");
    a_data: assert property (p_data) else $error("alarm data high");
    a_off: assert property (p_off) else $error("active while off");
    a_supply: assert property (p_supply) else $error("supply");
    a_cell: assert property (p_cell) else $error("cell");
    a_heat: assert property (p_heat) else $error("heat");
    a_therm: assert property (p_therm) else $error("therm");
    a_alarm: assert property (p_alarm) else $error("alarm on");
    a_blank: assert property (p_blank) else $error("blank");
endmodule : prot_seq_checker

// *** tb/host_model.sv ***
// Host model: drives the active-low enable, watches the alarm line.
// Assumes a board pull-up on the open-drain alarm line.
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic mclk,
    // Alarm pin parts from the sequencer
    input wire logic alarmOut,
    input wire logic alarmOe,
    // Enable and resolved alarm line
    output logic     enableN,
    output logic     alarmLine
);
    // A released line floats up to the pull-up level.
    assign alarmLine = alarmOe ? alarmOut : 1'b1;
    initial enableN = 1'b1;
    task automatic setEnable(input logic on);
        @(posedge mclk);
        enableN <= !on;
    endtask : setEnable
endmodule : host_model

// *** tb/testbench.sv ***
// Self-checking testbench of the protection fault sequencer.
// Assumes the checker and host model are compiled first.
`timescale 1ns/1ps
`define CHECK(g, e, m) begin checks_done++; if ((g) !== (e)) begin \
    err_count++; $display("MISMATCH %0t %s", $time, m); end end
module testbench;
    logic        mclk, rstn, supplyOverRise, supplyOverFall;
    logic        cellOverRise, cellOverFall, overcurrentTrip;
    logic        heatOverRise, heatOverFall, thermAboveCold, thermBelowHot;
    logic        thermGrounded, enableN, alarmLine, switchOn, currentLimit;
    logic        alarmOut, alarmOe, wbCyc, wbStb, wbWe, wbAck, irq;
    logic [3:0]  wbAdr, wbSel;
    logic [31:0] wbDatI, wbDatO, rdv;
    int          err_count, checks_done;
    protection_fault_sequencer u_dut (.mclk(mclk), .rstn(rstn),
        .supplyOverRise(supplyOverRise), .supplyOverFall(supplyOverFall),
        .cellOverRise(cellOverRise), .cellOverFall(cellOverFall),
        .overcurrentTrip(overcurrentTrip), .heatOverRise(heatOverRise),
        .heatOverFall(heatOverFall), .thermAboveCold(thermAboveCold),
        .thermBelowHot(thermBelowHot), .thermGrounded(thermGrounded),
        .enableN(enableN), .switchOn(switchOn), .currentLimit(currentLimit),
        .alarmOut(alarmOut), .alarmOe(alarmOe), .wbCyc(wbCyc), .wbStb(wbStb),
        .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
        .wbDatO(wbDatO), .wbAck(wbAck), .irq(irq));
    host_model u_host (.mclk(mclk), .alarmOut(alarmOut), .alarmOe(alarmOe),
        .enableN(enableN), .alarmLine(alarmLine));
    always #5 mclk = ~mclk;
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic wbXfer(input logic we, input logic [3:0] adr,
                          input logic [31:0] wd);
        @(posedge mclk);
        {wbCyc, wbStb, wbWe, wbAdr} <= {2'h3, we, adr};
        {wbSel, wbDatI} <= {4'hF, wd};
        do begin
            @(posedge mclk);
        end while (wbAck !== 1'b1);
        rdv = wbDatO;
        {wbCyc, wbStb, wbWe} <= 3'h0;
    endtask : wbXfer
    task automatic setFault(input int k, input logic v);
        @(posedge mclk);
        case (k)
            0: {heatOverRise, heatOverFall} <= {v, v};
            1: thermAboveCold <= v;
            default: thermBelowHot <= v;
        endcase
    endtask : setFault
    task automatic toggleEnable();
        u_host.setEnable(1'b0);
        tick(10);
        `CHECK(alarmLine, 1'b1, "alarm held while off")
        u_host.setEnable(1'b1);
        tick(12);
    endtask : toggleEnable
    task automatic summarize();
        if (err_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        summarize();
    end
    initial begin
        {mclk, rstn, supplyOverRise, supplyOverFall, cellOverRise} = 5'h0;
        {cellOverFall, overcurrentTrip, heatOverRise, heatOverFall} = 4'h0;
        {thermAboveCold, thermBelowHot, thermGrounded, wbCyc, wbStb} = 5'h0;
        {wbWe, wbAdr, wbSel, wbDatI} = 41'h0;
        tick(8);
        rstn <= 1'b1;
        tick(4);
        `CHECK({switchOn, alarmLine}, 2'h1, "closed while off")
        u_host.setEnable(1'b1);
        tick(12);
        `CHECK(switchOn, 1'b1, "on after enable")
        `CHECK(alarmLine, 1'b1, "alarm idle")
        wbXfer(1'b0, prot_seq_pkg::OFF_ENABLE, 32'h0);
        `CHECK(rdv[5:0], prot_seq_pkg::IRQ_EN_RST, "enable reset")
        wbXfer(1'b0, 4'h2, 32'h0);
        `CHECK(rdv, 32'h0, "unmapped read")
        wbXfer(1'b1, prot_seq_pkg::OFF_ENABLE, 32'h3F);
        @(posedge mclk);
        {supplyOverRise, supplyOverFall} <= 2'h3;
        tick(10);
        `CHECK({switchOn, alarmLine, irq}, 3'h1, "supply fault")
        wbXfer(1'b0, prot_seq_pkg::OFF_STATUS, 32'h0);
        `CHECK(rdv, 32'h1 << prot_seq_pkg::EV_SUPPLY, "supply status")
        @(posedge mclk);
        supplyOverRise <= 1'b0;
        tick(10);
        `CHECK(switchOn, 1'b0, "above release")
        @(posedge mclk);
        supplyOverFall <= 1'b0;
        tick(prot_seq_pkg::DEGLITCH_CYC / 2);
        `CHECK(switchOn, 1'b0, "deglitch early")
        tick(prot_seq_pkg::DEGLITCH_CYC);
        `CHECK({switchOn, alarmLine}, 2'h3, "supply recovery")
        wbXfer(1'b1, prot_seq_pkg::OFF_ENABLE, 32'h0);
        tick(1);
        `CHECK(irq, 1'b0, "masked irq")
        wbXfer(1'b1, prot_seq_pkg::OFF_ENABLE, 32'h3F);
        wbXfer(1'b1, prot_seq_pkg::OFF_CLEAR, 32'h3F);
        wbXfer(1'b0, prot_seq_pkg::OFF_STATUS, 32'h0);
        `CHECK({rdv, irq}, 33'h0, "status cleared")
        for (int k = 0; k < 3; k++) begin
            setFault(k, 1'b1);
            tick(10);
            `CHECK({switchOn, alarmLine}, 2'h0, "fault opens")
            if (k == 0) begin
                @(posedge mclk);
                heatOverRise <= 1'b0;
                tick(10);
                `CHECK(switchOn, 1'b0, "heat hysteresis")
            end
            setFault(k, 1'b0);
            tick(10);
            `CHECK(switchOn, 1'b1, "fault recovery")
        end
        @(posedge mclk);
        {thermGrounded, thermAboveCold} <= 2'h3;
        tick(10);
        `CHECK({switchOn, alarmLine}, 2'h3, "window ignored")
        @(posedge mclk);
        {thermGrounded, thermAboveCold} <= 2'h0;
        overcurrentTrip <= 1'b1;
        tick(10);
        `CHECK({currentLimit, switchOn}, 2'h3, "blanking")
        tick(prot_seq_pkg::BLANK_CYC / 2);
        overcurrentTrip <= 1'b0;
        tick(10);
        `CHECK({currentLimit, switchOn, alarmLine}, 3'h3, "blank ok")
        overcurrentTrip <= 1'b1;
        tick(prot_seq_pkg::BLANK_CYC - 20);
        `CHECK(switchOn, 1'b1, "blank not over")
        tick(40);
        overcurrentTrip <= 1'b0;
        tick(1000);
        `CHECK({switchOn, alarmLine}, 2'h0, "hiccup off")
        wbXfer(1'b0, prot_seq_pkg::OFF_STATE, 32'h0);
        `CHECK(rdv[11:8], 4'h1, "one fault counted")
        toggleEnable();
        wbXfer(1'b0, prot_seq_pkg::OFF_STATE, 32'h0);
        `CHECK({switchOn, rdv[11:8]}, 5'h10, "count cleared")
        for (int i = 1; i <= 15; i++) begin
            {cellOverRise, cellOverFall} <= 2'h3;
            tick(10);
            `CHECK({switchOn, alarmLine}, 2'h0, "cell fault")
            cellOverRise <= 1'b0;
            tick(10);
            `CHECK(switchOn, 1'b0, "cell hysteresis")
            cellOverFall <= 1'b0;
            tick(10);
            `CHECK(switchOn, 1'(i < 15), "cell recovery")
        end
        wbXfer(1'b0, prot_seq_pkg::OFF_STATE, 32'h0);
        `CHECK(rdv[15:12], prot_seq_pkg::FAULT_LIMIT, "cell count")
        wbXfer(1'b0, prot_seq_pkg::OFF_STATUS, 32'h0);
        `CHECK(rdv[prot_seq_pkg::EV_LOCK], 1'b1, "lockout status")
        toggleEnable();
        wbXfer(1'b0, prot_seq_pkg::OFF_STATE, 32'h0);
        `CHECK({switchOn, rdv[15:12]}, 5'h10, "lock cleared")
        summarize();
    end
endmodule : testbench
bind protection_fault_sequencer prot_seq_checker u_chk (.mclk(mclk),
    .rstn(rstn), .supplyOverRise(supplyOverRise), .cellOverRise(cellOverRise),
    .heatOverRise(heatOverRise), .thermAboveCold(thermAboveCold),
    .thermGrounded(thermGrounded), .enableN(enableN), .switchOn(switchOn),
    .currentLimit(currentLimit), .alarmOut(alarmOut), .alarmOe(alarmOe),
    .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck));
